// *** logic/hbp_pkg.sv ***
// hbp_pkg: shared constants and types for the h-bridge pwm and watchdog block
// assumes a 200 MHz pclk; settings count at the 40 MHz rate (25 ns)
package hbp_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 32'h5;          // pclk period, ns
  localparam int COUNT_NS      = 32'h19;         // one setting count, 25 ns
  localparam int TICK_CYCLES   = COUNT_NS / CLK_PERIOD_NS;
  localparam int SEC_NS        = 32'h3b9a_ca00;  // one second, ns
  localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
  localparam int FD_STEP       = 32'h8;          // counts per fast decay step
  localparam int SET_W         = 32'hd;          // 13-bit time settings
  localparam int FD_W          = 32'h4;          // fast decay portion width

  // watchdog timeouts in seconds: 60, 180, 300
  localparam logic [8:0] WDT_T1_S = 9'h03c;
  localparam logic [8:0] WDT_T2_S = 9'h0b4;
  localparam logic [8:0] WDT_T3_S = 9'h12c;

  // ---------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_WDT_A  = 8'h00;
  localparam logic [7:0] ADDR_WDT_B  = 8'h04;
  localparam logic [7:0] ADDR_CYC_A  = 8'h08;
  localparam logic [7:0] ADDR_CYC_B  = 8'h0c;
  localparam logic [7:0] ADDR_ON_A   = 8'h10;
  localparam logic [7:0] ADDR_ON_B   = 8'h14;
  localparam logic [7:0] ADDR_GEN    = 8'h18;
  localparam logic [7:0] ADDR_STAT   = 8'h1c;
  localparam int WDT_SEL_LSB   = 32'h0;  // wdt reg: timeout select [1:0]
  localparam int WDT_START_BIT = 32'h4;  // wdt reg: start flag
  localparam int ON_DIR_BIT    = 32'hd;  // on-time reg: direction
  localparam int GEN_DIR_LSB   = 32'h0;  // general: dir a, dir b
  localparam int GEN_DECAY_LSB = 32'h4;  // general: 2 bits per bridge
  localparam int GEN_FD_LSB    = 32'h8;  // general: 4 bits per bridge
  localparam int ST_TRIP_LSB   = 32'h0;  // status: trip a, b
  localparam int ST_EXT_LSB    = 32'h2;  // status: external mode a, b
  localparam int ST_DIR_LSB    = 32'h4;  // status: applied dir a, b
  localparam int ST_PH_LSB     = 32'h8;  // status: 2-bit phase per bridge

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HBP_DECAY_MIXED = 2'b00,
    HBP_DECAY_SLOW  = 2'b01,
    HBP_DECAY_FAST  = 2'b10
  } hbp_decay_type;

  typedef enum logic [1:0] {
    HBP_PH_ON   = 2'b00,
    HBP_PH_FAST = 2'b01,
    HBP_PH_SLOW = 2'b10
  } hbp_phase_type;

  typedef enum logic [1:0] {
    HBP_WDT_NEVER = 2'b00,
    HBP_WDT_T1    = 2'b01,
    HBP_WDT_T2    = 2'b10,
    HBP_WDT_T3    = 2'b11
  } hbp_wdt_type;

endpackage

// *** logic/hbp_pwm_chan.sv ***
// hbp_pwm_chan: one bridge's pwm period, on time and decay phase
// assumes tick pulses once per 25 ns count, synchronous to pclk
`timescale 1ns/10ps
module hbp_pwm_chan
#(
  parameter int W   = hbp_pkg::SET_W,
  parameter int FDW = hbp_pkg::FD_W
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   tick,
  input  wire logic [W-1:0]           cycle,
  input  wire logic [W-1:0]           ontime,
  input  wire logic                   ext_en,
  input  wire hbp_pkg::hbp_decay_type mode,
  input  wire logic [FDW-1:0]         fd_n,
  output hbp_pkg::hbp_phase_type      phase_q
);

  logic                   ext_mode;
  logic                   on_now;
  logic [W-1:0]           cnt_q;
  logic [W-1:0]           off_q;
  logic [W-1:0]           off_pos;
  logic [W-1:0]           fd_len;
  hbp_pkg::hbp_phase_type phase_d;

  // zero period hands the bridge to the enable pin
  // pin versus internal
  assign ext_mode = (cycle == '0);
  // fast portion of the decay interval in counts
  assign fd_len   = W'((32'(fd_n) + 1) * hbp_pkg::FD_STEP);

  // period counter, one step per count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (ext_mode)
      cnt_q <= '0;
    else if (tick)
    begin
      if (cnt_q >= cycle - 1'b1)
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  // decay time since the enable pin fell
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      off_q <= '0;
    else if (ext_en)
      off_q <= '0;
    else if (tick && off_q != '1)
      off_q <= off_q + 1'b1;
  end

  // on for ontime counts; full on when ontime >= period
  assign on_now  = ext_mode ? ext_en : (cnt_q < ontime);
  assign off_pos = ext_mode ? off_q : W'(cnt_q - ontime);

  // pick on, fast or slow for the next cycle
  always_comb
  begin
    phase_d = hbp_pkg::HBP_PH_SLOW;
    if (on_now)
      phase_d = hbp_pkg::HBP_PH_ON;
    else
    begin
      case (mode)
        hbp_pkg::HBP_DECAY_FAST: phase_d = hbp_pkg::HBP_PH_FAST;
        hbp_pkg::HBP_DECAY_SLOW: phase_d = hbp_pkg::HBP_PH_SLOW;
        hbp_pkg::HBP_DECAY_MIXED:
          phase_d = (off_pos < fd_len) ? hbp_pkg::HBP_PH_FAST : hbp_pkg::HBP_PH_SLOW;
        default: phase_d = hbp_pkg::HBP_PH_SLOW;
      endcase
    end
  end

  // registered phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_q <= hbp_pkg::HBP_PH_SLOW;
    else
      phase_q <= phase_d;
  end

endmodule

// *** logic/hbp_wdog.sv ***
// hbp_wdog: one side's watchdog counter with latched trip
// assumes start and sel are register levels, restart a one-cycle pulse
`timescale 1ns/10ps
module hbp_wdog
#(
  parameter int unsigned SEC_CYCLES = hbp_pkg::SEC_CYCLES
)
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire hbp_pkg::hbp_wdt_type sel,
  input  wire logic                 start,
  input  wire logic                 restart,
  output logic                      trip_q
);

  localparam int PW = $clog2(SEC_CYCLES + 1);

  logic          running;
  logic [PW-1:0] pre_q;
  logic [8:0]    sec_q;
  logic [8:0]    limit;

  assign running = start && (sel != hbp_pkg::HBP_WDT_NEVER);

  always_comb
  begin
    case (sel)
      hbp_pkg::HBP_WDT_T1: limit = hbp_pkg::WDT_T1_S;
      hbp_pkg::HBP_WDT_T2: limit = hbp_pkg::WDT_T2_S;
      hbp_pkg::HBP_WDT_T3: limit = hbp_pkg::WDT_T3_S;
      default:             limit = '1;
    endcase
  end

  // second prescaler and seconds count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q <= '0;
      sec_q <= '0;
    end
    // clear flag resets count; rewrite restarts
    else if (!running || restart)
    begin
      pre_q <= '0;
      sec_q <= '0;
    end
    else if (pre_q == PW'(SEC_CYCLES - 1))
    begin
      pre_q <= '0;
      if (sec_q != '1)
        sec_q <= sec_q + 1'b1;
    end
    else
      pre_q <= pre_q + 1'b1;
  end

  // timeout trips; latched, clear wins over set
  // a rewrite zeroes the count, so its stale value cannot set again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trip_q <= 1'b0;
    else if (running && !restart && sec_q >= limit)
      trip_q <= 1'b1;
    else if (!start || restart)
      trip_q <= 1'b0;
  end

endmodule

// *** logic/hbp_top.sv ***
// hbp_top: two-bridge pwm timing, direction and watchdog with apb registers
// assumes an apb master on pclk and a power stage following the pin levels
//
// Behaviour
// - last direction write, any register, wins
// - period is n counts of 25 ns
// - zero period selects the enable pin
// - on time is n counts of 25 ns
// - on from period start, then decay
// - decay off portion per selected mode
// - timeout select: never, 60, 180, 300 s
// - start flag counts, clearing resets count
// - timeout turns that side's outputs off
// - separate watchdog per bridge
// - timeout rewrite restarts the count
// - mixed decay: fast first, slow remainder
// - one count is one 40 MHz period
// - dir 1 forward pos high, 0 reverse
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module hbp_top
#(
  parameter int unsigned SEC_CYCLES = hbp_pkg::SEC_CYCLES,
  parameter int          W          = hbp_pkg::SET_W,
  parameter int          FDW        = hbp_pkg::FD_W
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  bridge_enable_pin,
  output logic [1:0]       bridge_out_pos,
  output logic [1:0]       bridge_out_neg,
  output logic [1:0]       bridge_out_hiz
);

  localparam int TW = $clog2(hbp_pkg::TICK_CYCLES);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [TW-1:0]          tick_q;
  logic                   tick;
  logic [W-1:0]           cycle_q  [2];
  logic [W-1:0]           ontime_q [2];
  logic [1:0]             dir_q;
  hbp_pkg::hbp_decay_type decay_q  [2];
  logic [FDW-1:0]         fdn_q    [2];
  hbp_pkg::hbp_wdt_type   wsel_q   [2];
  logic [1:0]             wstart_q;
  logic [1:0]             wrestart;
  logic [1:0]             trip;
  logic [1:0]             ext_mode;
  hbp_pkg::hbp_phase_type phase    [2];
  logic [31:0]            rd_d;
  logic [31:0]            rdata_q;
  logic                   addr_hit;
  logic                   wr_en;
  logic                   setup;
  logic [7:0]             addr_wdt [2];
  logic [7:0]             addr_cyc [2];
  logic [7:0]             addr_on  [2];

  // per-bridge register addresses
  assign addr_wdt[0] = hbp_pkg::ADDR_WDT_A;
  assign addr_wdt[1] = hbp_pkg::ADDR_WDT_B;
  assign addr_cyc[0] = hbp_pkg::ADDR_CYC_A;
  assign addr_cyc[1] = hbp_pkg::ADDR_CYC_B;
  assign addr_on[0]  = hbp_pkg::ADDR_ON_A;
  assign addr_on[1]  = hbp_pkg::ADDR_ON_B;

  // ---------------------------------------------------------------
  // count tick
  // ---------------------------------------------------------------

  // one count every 40 MHz period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_q <= '0;
    else if (tick)
      tick_q <= '0;
    else
      tick_q <= tick_q + 1'b1;
  end

  assign tick = (tick_q == TW'(hbp_pkg::TICK_CYCLES - 1));

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------

  // zero wait states: read data is captured in the setup cycle
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && addr_hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata  = rdata_q;

  // address decode
  always_comb
  begin
    case (paddr)
      hbp_pkg::ADDR_WDT_A,
      hbp_pkg::ADDR_WDT_B,
      hbp_pkg::ADDR_CYC_A,
      hbp_pkg::ADDR_CYC_B,
      hbp_pkg::ADDR_ON_A,
      hbp_pkg::ADDR_ON_B,
      hbp_pkg::ADDR_GEN,
      hbp_pkg::ADDR_STAT: addr_hit = 1'b1;
      default:            addr_hit = 1'b0;
    endcase
  end

  // read mux
  always_comb
  begin
    rd_d = '0;
    case (paddr)
      hbp_pkg::ADDR_WDT_A:
      begin
        rd_d[hbp_pkg::WDT_SEL_LSB +: 2]  = wsel_q[0];
        rd_d[hbp_pkg::WDT_START_BIT]     = wstart_q[0];
      end
      hbp_pkg::ADDR_WDT_B:
      begin
        rd_d[hbp_pkg::WDT_SEL_LSB +: 2]  = wsel_q[1];
        rd_d[hbp_pkg::WDT_START_BIT]     = wstart_q[1];
      end
      hbp_pkg::ADDR_CYC_A: rd_d[W-1:0] = cycle_q[0];
      hbp_pkg::ADDR_CYC_B: rd_d[W-1:0] = cycle_q[1];
      hbp_pkg::ADDR_ON_A:
      begin
        rd_d[W-1:0]                 = ontime_q[0];
        rd_d[hbp_pkg::ON_DIR_BIT]   = dir_q[0];
      end
      hbp_pkg::ADDR_ON_B:
      begin
        rd_d[W-1:0]                 = ontime_q[1];
        rd_d[hbp_pkg::ON_DIR_BIT]   = dir_q[1];
      end
      hbp_pkg::ADDR_GEN:
      begin
        rd_d[hbp_pkg::GEN_DIR_LSB +: 2]        = dir_q;
        rd_d[hbp_pkg::GEN_DECAY_LSB +: 2]      = decay_q[0];
        rd_d[hbp_pkg::GEN_DECAY_LSB + 2 +: 2]  = decay_q[1];
        rd_d[hbp_pkg::GEN_FD_LSB +: FDW]       = fdn_q[0];
        rd_d[hbp_pkg::GEN_FD_LSB + FDW +: FDW] = fdn_q[1];
      end
      hbp_pkg::ADDR_STAT:
      begin
        rd_d[hbp_pkg::ST_TRIP_LSB +: 2]    = trip;
        rd_d[hbp_pkg::ST_EXT_LSB +: 2]     = ext_mode;
        rd_d[hbp_pkg::ST_DIR_LSB +: 2]     = dir_q;
        rd_d[hbp_pkg::ST_PH_LSB +: 2]      = phase[0];
        rd_d[hbp_pkg::ST_PH_LSB + 2 +: 2]  = phase[1];
      end
      default: rd_d = '0;
    endcase
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= '0;
    else if (setup)
      rdata_q <= rd_d;
  end

  // ---------------------------------------------------------------
  // direction, shared by two words per bridge
  // ---------------------------------------------------------------

  // whichever word is written last sets the direction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_q <= '0;
    else if (wr_en && paddr == hbp_pkg::ADDR_GEN)
      dir_q <= pwdata[hbp_pkg::GEN_DIR_LSB +: 2];
    else if (wr_en && paddr == hbp_pkg::ADDR_ON_A)
      dir_q[0] <= pwdata[hbp_pkg::ON_DIR_BIT];
    else if (wr_en && paddr == hbp_pkg::ADDR_ON_B)
      dir_q[1] <= pwdata[hbp_pkg::ON_DIR_BIT];
  end

  // ---------------------------------------------------------------
  // per-bridge settings, watchdog and pins
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_br

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cycle_q[i] <= '0;
        else if (wr_en && paddr == addr_cyc[i])
          cycle_q[i] <= pwdata[W-1:0];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ontime_q[i] <= '0;
        else if (wr_en && paddr == addr_on[i])
          ontime_q[i] <= pwdata[W-1:0];
      end

      // decay mode and fast portion
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          decay_q[i] <= hbp_pkg::HBP_DECAY_MIXED;
          fdn_q[i]   <= '0;
        end
        else if (wr_en && paddr == hbp_pkg::ADDR_GEN)
        begin
          decay_q[i] <= hbp_pkg::hbp_decay_type'(pwdata[hbp_pkg::GEN_DECAY_LSB + 2*i +: 2]);
          fdn_q[i]   <= pwdata[hbp_pkg::GEN_FD_LSB + FDW*i +: FDW];
        end
      end

      // own timeout and start flag per bridge
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          wsel_q[i]   <= hbp_pkg::HBP_WDT_NEVER;
          wstart_q[i] <= 1'b0;
        end
        else if (wr_en && paddr == addr_wdt[i])
        begin
          wsel_q[i]   <= hbp_pkg::hbp_wdt_type'(pwdata[hbp_pkg::WDT_SEL_LSB +: 2]);
          wstart_q[i] <= pwdata[hbp_pkg::WDT_START_BIT];
        end
      end

      // any write of the timeout register restarts the count
      assign wrestart[i] = wr_en && (paddr == addr_wdt[i]);
      assign ext_mode[i] = (cycle_q[i] == '0);

      // pwm timing for this bridge
      hbp_pwm_chan
      #(
        .W   (W),
        .FDW (FDW)
      )
      u_pwm
      (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .cycle   (cycle_q[i]),
        .ontime  (ontime_q[i]),
        .ext_en  (bridge_enable_pin[i]),
        .mode    (decay_q[i]),
        .fd_n    (fdn_q[i]),
        .phase_q (phase[i])
      );

      // watchdog for this bridge
      hbp_wdog
      #(
        .SEC_CYCLES (SEC_CYCLES)
      )
      u_wdog
      (
        .pclk    (pclk),
        .presetn (presetn),
        .sel     (wsel_q[i]),
        .start   (wstart_q[i]),
        .restart (wrestart[i]),
        .trip_q  (trip[i])
      );

      // pin levels from phase, direction and trip
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          bridge_out_pos[i] <= 1'b0;
          bridge_out_neg[i] <= 1'b0;
          bridge_out_hiz[i] <= 1'b0;
        end
        else if (trip[i])
        begin
          bridge_out_pos[i] <= 1'b0;
          bridge_out_neg[i] <= 1'b0;
          bridge_out_hiz[i] <= 1'b1;
        end
        else
        begin
          bridge_out_hiz[i] <= 1'b0;
          case (phase[i])
            hbp_pkg::HBP_PH_ON:
            begin
              bridge_out_pos[i] <= dir_q[i];
              bridge_out_neg[i] <= !dir_q[i];
            end
            // fast decay reverses the bridge voltage
            hbp_pkg::HBP_PH_FAST:
            begin
              bridge_out_pos[i] <= !dir_q[i];
              bridge_out_neg[i] <= dir_q[i];
            end
            // slow decay shorts both low sides
            default:
            begin
              bridge_out_pos[i] <= 1'b0;
              bridge_out_neg[i] <= 1'b0;
            end
          endcase
        end
      end

    end
  endgenerate

endmodule

// *** verif/hbp_stage_model.sv ***
// hbp_stage_model: power stage behind one bridge's output pins
// assumes pin levels registered on pclk; clr is a level from the bench
`timescale 1ns/10ps
module hbp_stage_model
(
  input  wire logic   pclk,
  input  wire logic   clr,
  input  wire logic   pos,
  input  wire logic   neg,
  input  wire logic   off,
  output logic [15:0] pos_cnt,
  output logic [15:0] neg_cnt
);
  // -------------------------------------------------------------
  // coil drive counters
  // -------------------------------------------------------------
  // off leaves coil undriven
  always_ff @(posedge pclk)
  begin
    if (clr)
    begin
      pos_cnt <= 16'h0;
      neg_cnt <= 16'h0;
    end
    else
    begin
      pos_cnt <= pos_cnt + {15'h0, pos && !off};
      neg_cnt <= neg_cnt + {15'h0, neg && !off};
    end
  end
endmodule

// *** verif/hbp_top_properties.sv ***
// hbp_top_properties: port checker for hbp_top
// assumes apb requests held until pready; bound after the module
`timescale 1ns/10ps
module hbp_top_properties
#(
  parameter int unsigned SEC_CYCLES = 10,
  parameter int          W          = 13,
  parameter int          FDW        = 4
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  bridge_enable_pin,
  input wire logic [1:0]  bridge_out_pos,
  input wire logic [1:0]  bridge_out_neg,
  input wire logic [1:0]  bridge_out_hiz
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [12:0] cyc_a_q;
  logic [12:0] cyc_b_q;
  logic [1:0]  dir_q;
  logic [4:0]  wdt_a_q;
  logic [31:0] cnt_a_q;
  logic [31:0] lim_a;
  logic        wr;

  // -------------------------------------------------------------
  // shadow of written settings
  // -------------------------------------------------------------
  assign wr = psel && penable && pwrite;
  assign lim_a = SEC_CYCLES * (wdt_a_q[1:0] == 2'h1 ? 32'h3c :
                 (wdt_a_q[1:0] == 2'h2 ? 32'hb4 : 32'h12c));

  // latest direction from any register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_a_q <= 13'h0;
      cyc_b_q <= 13'h0;
      dir_q   <= 2'h0;
      wdt_a_q <= 5'h0;
    end
    else if (wr)
    begin
      if (paddr == hbp_pkg::ADDR_CYC_A) cyc_a_q <= pwdata[12:0];
      if (paddr == hbp_pkg::ADDR_CYC_B) cyc_b_q <= pwdata[12:0];
      if (paddr == hbp_pkg::ADDR_GEN) dir_q <= pwdata[1:0];
      if (paddr == hbp_pkg::ADDR_ON_A) dir_q[0] <= pwdata[13];
      if (paddr == hbp_pkg::ADDR_ON_B) dir_q[1] <= pwdata[13];
      if (paddr == hbp_pkg::ADDR_WDT_A) wdt_a_q <= pwdata[4:0];
    end
  end

  // watchdog a running count, restarted by any write of the watchdog a register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_a_q <= 32'h0;
    else if (wr && paddr == hbp_pkg::ADDR_WDT_A)
      cnt_a_q <= 32'h0;
    else if (wdt_a_q[4] && wdt_a_q[1:0] != 2'h0)
      cnt_a_q <= cnt_a_q + 32'h1;
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  // pin-high drive checks a and b, pin-low checks a only; trip checks a
  a_ext_pin_on: assert property (
    (cyc_a_q == 13'h0 && bridge_enable_pin[0] && !bridge_out_hiz[0] && $stable(dir_q[0]))[*3]
    |-> bridge_out_pos[0] == dir_q[0] && bridge_out_neg[0] != dir_q[0])
    else $error("bridge a not on with pin high");
  a_ext_pin_b: assert property (
    (cyc_b_q == 13'h0 && bridge_enable_pin[1] && !bridge_out_hiz[1] && $stable(dir_q[1]))[*3]
    |-> bridge_out_pos[1] == dir_q[1] && bridge_out_neg[1] != dir_q[1])
    else $error("bridge b not on with pin high");
  a_ext_pin_off: assert property (
    (cyc_a_q == 13'h0 && !bridge_enable_pin[0] && $stable(dir_q[0]))[*3]
    |-> !(bridge_out_pos[0] == dir_q[0] && bridge_out_neg[0] != dir_q[0]))
    else $error("bridge a on with pin low");
  a_never_both: assert property (
    (bridge_out_pos & bridge_out_neg) == 2'h0)
    else $error("both outputs high");
  a_hiz_quiet: assert property (
    (bridge_out_hiz & (bridge_out_pos | bridge_out_neg)) == 2'h0)
    else $error("output driven while turned off");
  a_trip_cause: assert property (
    $rose(bridge_out_hiz[0]) |-> $past(wdt_a_q[4]) && $past(wdt_a_q[1:0]) != 2'h0)
    else $error("trip without running count");
  a_trip_time: assert property (
    $rose(bridge_out_hiz[0]) |-> $past(cnt_a_q) + 32'h2 >= $past(lim_a)
    && $past(cnt_a_q) <= $past(lim_a) + 32'h5)
    else $error("trip at wrong count");
  a_trip_latch: assert property (
    $fell(bridge_out_hiz[0]) |-> $past(wr && paddr == hbp_pkg::ADDR_WDT_A)
    || $past(wr && paddr == hbp_pkg::ADDR_WDT_A, 2))
    else $error("trip released without write");
endmodule

bind hbp_top hbp_top_properties #(.SEC_CYCLES(SEC_CYCLES), .W(W), .FDW(FDW)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .bridge_enable_pin, .bridge_out_pos, .bridge_out_neg, .bridge_out_hiz);

// *** verif/hbp_top_tb.sv ***
// hbp_top_tb: self-checking bench for hbp_top
// assumes a shortened watchdog second; pclk 200 MHz
`timescale 1ns/10ps
module hbp_top_tb;
  localparam int unsigned SEC = 10;
  logic        pclk, presetn, psel, penable, pwrite, clr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic        pready, pslverr;
  logic [1:0]  bridge_enable_pin, bridge_out_pos, bridge_out_neg, bridge_out_hiz, xdir;
  logic [15:0] pcnt [2];
  logic [15:0] ncnt [2];
  int          n_errors, samples_checked, v, n, o, fd, m, b, lim;

  // -------------------------------------------------------------
  // clock, design and power stage
  // -------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  hbp_top #(.SEC_CYCLES(SEC)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bridge_enable_pin, .bridge_out_pos,
    .bridge_out_neg, .bridge_out_hiz);

  for (genvar i = 0; i < 2; i++)
  begin : g_stage
    hbp_stage_model u_stage (.pclk, .clr, .pos(bridge_out_pos[i]), .neg(bridge_out_neg[i]),
      .off(bridge_out_hiz[i]), .pos_cnt(pcnt[i]), .neg_cnt(ncnt[i]));
  end

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // fast decay counts per period
  function automatic int fast_cnt(input int m, input int n, input int o, input int fd);
    int off;
    off = (o >= n) ? 0 : n - o;
    if (m == 1)
      return 0;
    if (m == 2 || off < (fd + 1) * 8)
      return off;
    return (fd + 1) * 8;
  endfunction

  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, bridge_enable_pin} = '0;
    clr = 1'b1;
    void'($urandom(32'h6910));
    cyc(12);
    presetn <= 1'b1;
    // reset values; status shows pin mode
    for (int a = 0; a < 8; a++)
    begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk(rd & (a == 7 ? 32'h3f : 32'hffff_ffff), a == 7 ? 32'hc : 32'h0);
    end
    apb(1'b1, 8'h40, 32'hffff_ffff);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // random direction writes, pins toggling
    xdir = 2'h0;
    for (int i = 0; i < 12; i++)
    begin
      v = $urandom % 3;
      d = $urandom & (v == 0 ? 32'h3 : 32'h3fff);
      bridge_enable_pin <= 2'($urandom);
      if (v == 0)
        xdir = d[1:0];
      else
        xdir[v - 1] = d[13];
      apb(1'b1, v == 0 ? hbp_pkg::ADDR_GEN : 8'(12 + v * 4), d);
      cyc(4);
      apb(1'b0, hbp_pkg::ADDR_STAT, 32'h0);
      chk({30'h0, rd[5:4]}, {30'h0, xdir});
      chk({bridge_out_pos, bridge_out_neg} & {2{bridge_enable_pin}},
          {xdir, ~xdir} & {2{bridge_enable_pin}});
    end
    bridge_enable_pin <= 2'h0;
    // internal pwm, each decay mode on each bridge
    for (int k = 0; k < 6; k++)
    begin
      b = k % 2;
      m = k / 2;
      n = 2 + $urandom % 30;
      o = (k == 4) ? n + 3 : $urandom % (n + 1);
      fd = $urandom % 2;
      apb(1'b1, hbp_pkg::ADDR_GEN, 32'(3 | (m << (4 + 2 * b)) | (fd << (8 + 4 * b))));
      apb(1'b1, 8'(16 + 4 * b), 32'(32'h2000 | o));
      apb(1'b1, 8'(8 + 4 * b), 32'(n));
      cyc(40 * n);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      cyc(20 * n);
      #1;
      chk({16'h0, pcnt[b]}, 32'(20 * (o < n ? o : n)));
      chk({16'h0, ncnt[b]}, 32'(20 * fast_cnt(m, n, o, fd)));
      apb(1'b1, 8'(8 + 4 * b), 32'h0);
    end
    // watchdog a per timeout, b left on never
    apb(1'b1, hbp_pkg::ADDR_WDT_B, 32'h10);
    for (int s = 1; s < 4; s++)
    begin
      lim = SEC * (s == 1 ? 60 : (s == 2 ? 180 : 300));
      apb(1'b1, hbp_pkg::ADDR_WDT_A, 32'(16 + s));
      cyc(lim - 10);
      chk({30'h0, bridge_out_hiz}, 32'h0);
      cyc(20);
      chk({30'h0, bridge_out_hiz}, 32'h1);
      apb(1'b1, hbp_pkg::ADDR_WDT_A, 32'(16 + s));
      cyc(lim / 2);
      chk({30'h0, bridge_out_hiz}, 32'h0);
      apb(1'b1, hbp_pkg::ADDR_WDT_A, 32'(16 + s));
      cyc(lim - 10);
      chk({30'h0, bridge_out_hiz}, 32'h0);
      apb(1'b1, hbp_pkg::ADDR_WDT_A, 32'(s));
      cyc(lim + 10);
      chk({30'h0, bridge_out_hiz}, 32'h0);
    end
    summarize();
  end

  // hang guard
  initial
  begin
    cyc(90000);
    n_errors++;
    summarize();
  end
endmodule
